// >>> src/rmnt_timers.sv
// Mask receive timer and no-response timer with register port and irq.
// Assumes tx_end, tx_off, reply and rx_data come from carrier-clock logic.
`timescale 1ns/1ns
`default_nettype none
module rmnt_timers
    import rmnt_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [5:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    input  wire logic        TX_END_I,
    input  wire logic        TX_OFF_I,
    input  wire logic        REPLY_I,
    input  wire logic        RX_DATA_I,
    output logic             RX_DATA_O,
    output logic             RX_MASKED_O,
    output logic             IRQ_O
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    rmnt_bus_t   bus;
    rmnt_mode_t  mode;
    rmnt_mode_t  next_mode;
    logic [7:0]  mask_time;
    logic [7:0]  next_mask_time;
    logic [7:0]  nr_high;
    logic [7:0]  next_nr_high;
    logic [7:0]  nr_low;
    logic [7:0]  next_nr_low;
    logic [7:0]  timer_ctrl;
    logic [7:0]  next_timer_ctrl;
    logic [1:0]  irq_status;
    logic [1:0]  next_irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  next_irq_mask;
    logic [7:0]  next_rdata;
    logic        next_irq;
    logic        next_rx_data;
    logic        next_rx_masked;
    logic [1:0]  irq_event;
    logic [1:0]  irq_clear;

    // ------------------------------------------------------------
    // Command decode and timer wiring
    // ------------------------------------------------------------
    logic        set_default;
    logic        cmd_start_nr;
    logic        mask_busy;
    logic        mask_done;
    logic        nr_busy;
    logic        nr_done;
    logic        nr_start;
    logic        mask_start;
    logic [15:0] mask_steps;
    logic [15:0] nr_value;
    logic [RMNT_PRESC_W:0] mask_len;
    logic [RMNT_PRESC_W:0] nr_len;

    // ------------------------------------------------------------
    // Register bus capture
    // ------------------------------------------------------------
    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    assign set_default  = bus.wr && (bus.addr == RMNT_ADDR_COMMAND)
                          && bus.wdata[RMNT_CMD_SET_DEF];
    assign cmd_start_nr = bus.wr && (bus.addr == RMNT_ADDR_COMMAND)
                          && bus.wdata[RMNT_CMD_START_NR];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb begin
        next_mask_time  = mask_time;
        next_nr_high    = nr_high;
        next_nr_low     = nr_low;
        next_timer_ctrl = timer_ctrl;
        next_mode       = mode;
        next_irq_mask   = irq_mask;
        if (bus.wr) begin
            case (bus.addr)
                RMNT_ADDR_MASK_TIME:  next_mask_time  = bus.wdata;
                RMNT_ADDR_NR_HIGH:    next_nr_high    = bus.wdata;
                RMNT_ADDR_NR_LOW:     next_nr_low     = bus.wdata;
                RMNT_ADDR_TIMER_CTRL: next_timer_ctrl = bus.wdata;
                RMNT_ADDR_MODE: begin
                    next_mode.bitrate_detect = bus.wdata[RMNT_MODE_BITRATE];
                    next_mode.iso_a106       = bus.wdata[RMNT_MODE_ISO_A106];
                    next_mode.nfc_active     = bus.wdata[RMNT_MODE_NFC_ACT];
                end
                RMNT_ADDR_IRQ_MASK:   next_irq_mask   = bus.wdata[1:0];
                default: ;
            endcase
        end
        // Mode, mask and status are kept so the host's interrupt setup
        // survives a return to default timing
        // defaults on command
        if (set_default) begin
            next_mask_time  = RMNT_RST_MASK_TIME;
            next_nr_high    = RMNT_RST_NR_HIGH;
            next_nr_low     = RMNT_RST_NR_LOW;
            next_timer_ctrl = RMNT_RST_TIMER_CTRL;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mask_time  <= RMNT_RST_MASK_TIME;
            nr_high    <= RMNT_RST_NR_HIGH;
            nr_low     <= RMNT_RST_NR_LOW;
            timer_ctrl <= RMNT_RST_TIMER_CTRL;
            mode       <= rmnt_mode_t'(RMNT_RST_MODE[2:0]);
            irq_mask   <= RMNT_RST_IRQ_MASK[1:0];
        end else begin
            mask_time  <= next_mask_time;
            nr_high    <= next_nr_high;
            nr_low     <= next_nr_low;
            timer_ctrl <= next_timer_ctrl;
            mode       <= next_mode;
            irq_mask   <= next_irq_mask;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always_comb begin
        irq_event                    = 2'b00;
        irq_event[RMNT_IRQ_NO_REPLY] = nr_done;
        irq_event[RMNT_IRQ_MASK_END] = mask_done;
    end

    assign irq_clear = (bus.wr && (bus.addr == RMNT_ADDR_IRQ_STATUS))
                       ? bus.wdata[1:0] : 2'b00;

    // Set wins over a write-one clear in the same cycle, so an event
    // that lands on the clear is never lost
    for (genvar i = 0; i < 2; i++) begin : g_irq_bit
        assign next_irq_status[i] = irq_event[i]
                                    || (irq_status[i] && !irq_clear[i]);
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // ------------------------------------------------------------
    // Mask receive timer
    // ------------------------------------------------------------
    always_comb begin
        // Small counts are raised, not refused, so the register still
        // reads back exactly what was written
        // floor of four steps
        if (mask_time < 8'(RMNT_MASK_MIN_CNT)) begin
            mask_steps = 16'(RMNT_MASK_MIN_CNT);
        end else begin
            mask_steps = {8'h00, mask_time};
        end
        if (mode.bitrate_detect) begin
            mask_len = (RMNT_PRESC_W+1)'(RMNT_MASK_STEP_BRD);
        end else if (mode.iso_a106) begin
            // Half step has its own constant so the frame-delay grid can
            // move without touching the plain step
            // half frame-delay steps
            mask_len = (RMNT_PRESC_W+1)'(RMNT_FDT_HALF_STEP);
        end else begin
            mask_len = (RMNT_PRESC_W+1)'(RMNT_MASK_STEP);
        end
    end

    // mask starts at end of tx
    assign mask_start = TX_END_I;

    rmnt_step_counter u_mask (
        .clk_i      (REF_CLK_I),
        .rst_i      (RST_I),
        .start_i    (mask_start),
        .stop_i     (set_default),
        .steps_i    (mask_steps),
        .step_len_i (mask_len),
        .busy_o     (mask_busy),
        .done_o     (mask_done)
    );

    // ------------------------------------------------------------
    // No-response timer
    // ------------------------------------------------------------
    assign nr_value = {nr_high, nr_low};

    always_comb begin
        if (timer_ctrl[RMNT_CTRL_NR_STEP]) begin
            nr_len = (RMNT_PRESC_W+1)'(RMNT_NR_STEP_LONG);
        end else begin
            nr_len = (RMNT_PRESC_W+1)'(RMNT_NR_STEP_SHORT);
        end
    end

    // Start beats stop in the counter, so a restart on the cycle of
    // a reply re-arms the timer instead of leaving it idle
    // start sources; zero value never starts
    assign nr_start = (nr_value != 16'h0000)
                      && (cmd_start_nr
                          || (!mode.nfc_active && TX_END_I)
                          || (mode.nfc_active && TX_OFF_I));

    rmnt_step_counter u_noreply (
        .clk_i      (REF_CLK_I),
        .rst_i      (RST_I),
        .start_i    (nr_start),
        .stop_i     (REPLY_I || set_default),
        .steps_i    (nr_value),
        .step_len_i (nr_len),
        .busy_o     (nr_busy),
        .done_o     (nr_done)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                RMNT_ADDR_MASK_TIME:  next_rdata = mask_time;
                RMNT_ADDR_NR_HIGH:    next_rdata = nr_high;
                RMNT_ADDR_NR_LOW:     next_rdata = nr_low;
                RMNT_ADDR_TIMER_CTRL: next_rdata = timer_ctrl;
                RMNT_ADDR_MODE:       next_rdata = {5'h00, mode.nfc_active,
                                                    mode.iso_a106,
                                                    mode.bitrate_detect};
                RMNT_ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
                RMNT_ADDR_IRQ_MASK:   next_rdata = {6'h00, irq_mask};
                RMNT_ADDR_STATE:      next_rdata = {6'h00, nr_busy,
                                                    mask_busy};
                default:              next_rdata = 8'h00;
            endcase
        end
    end

    // Unread cycles return zero so a stale value is never mistaken
    // for an answer
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and receiver outputs
    // ------------------------------------------------------------
    always_comb begin
        // Next-state view keeps the interrupt in step with its status
        next_irq = |(next_irq_status & next_irq_mask);
        // blank receiver while masking
        // The start cycle is masked too, before the counter is busy
        next_rx_masked = mask_busy || mask_start;
        next_rx_data   = RX_DATA_I && !next_rx_masked;
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IRQ_O       <= 1'b0;
            RX_DATA_O   <= 1'b0;
            RX_MASKED_O <= 1'b0;
        end else begin
            IRQ_O       <= next_irq;
            RX_DATA_O   <= next_rx_data;
            RX_MASKED_O <= next_rx_masked;
        end
    end
endmodule : rmnt_timers
`default_nettype wire

// >>> pkg/rmnt_pkg.sv
// Package for the mask receive and no-response timer block.
// Assumes a single carrier-derived clock and a plain register port.
package rmnt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] RMNT_ADDR_MASK_TIME   = 6'h0E;
    localparam logic [5:0] RMNT_ADDR_NR_HIGH     = 6'h0F;
    localparam logic [5:0] RMNT_ADDR_NR_LOW      = 6'h10;
    localparam logic [5:0] RMNT_ADDR_TIMER_CTRL  = 6'h11;
    localparam logic [5:0] RMNT_ADDR_MODE        = 6'h30;
    localparam logic [5:0] RMNT_ADDR_IRQ_STATUS  = 6'h31;
    localparam logic [5:0] RMNT_ADDR_IRQ_MASK    = 6'h32;
    localparam logic [5:0] RMNT_ADDR_COMMAND     = 6'h33;
    localparam logic [5:0] RMNT_ADDR_STATE       = 6'h34;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RMNT_RST_MASK_TIME    = 8'h08;
    localparam logic [7:0] RMNT_RST_NR_HIGH      = 8'h00;
    localparam logic [7:0] RMNT_RST_NR_LOW       = 8'h00;
    localparam logic [7:0] RMNT_RST_TIMER_CTRL   = 8'h00;
    localparam logic [7:0] RMNT_RST_MODE         = 8'h00;
    localparam logic [7:0] RMNT_RST_IRQ_MASK     = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RMNT_CTRL_NR_STEP   = 0;
    localparam int RMNT_MODE_BITRATE   = 0;
    localparam int RMNT_MODE_ISO_A106  = 1;
    localparam int RMNT_MODE_NFC_ACT   = 2;
    localparam int RMNT_CMD_SET_DEF    = 0;
    localparam int RMNT_CMD_START_NR   = 1;
    localparam int RMNT_IRQ_NO_REPLY   = 0;
    localparam int RMNT_IRQ_MASK_END   = 1;

    // ------------------------------------------------------------
    // Step lengths in carrier periods, minimum mask step count and prescaler width
    // ------------------------------------------------------------
    localparam int RMNT_MASK_STEP      = 64;
    localparam int RMNT_MASK_STEP_BRD  = 512;
    localparam int RMNT_MASK_MIN_CNT   = 4;
    localparam int RMNT_NR_STEP_SHORT  = 64;
    localparam int RMNT_NR_STEP_LONG   = 4096;
    // Half frame-delay step for ISO14443A 106 kbit/s, carrier periods
    localparam int RMNT_FDT_HALF_STEP  = 64;
    localparam int RMNT_PRESC_W        = 12;

    typedef struct packed {
        logic       bitrate_detect;
        logic       iso_a106;
        logic       nfc_active;
    } rmnt_mode_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rmnt_bus_t;

endpackage : rmnt_pkg

// >>> src/rmnt_step_counter.sv
// Step counter: prescaler of carrier periods plus a step down-counter.
// Assumes start and stop are same-clock pulses; start wins over stop.
`timescale 1ns/1ns
`default_nettype none
module rmnt_step_counter
    import rmnt_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   start_i,
    input  wire logic                   stop_i,
    input  wire logic [15:0]            steps_i,
    input  wire logic [RMNT_PRESC_W:0]  step_len_i,
    output logic                        busy_o,
    output logic                        done_o
);
    logic [RMNT_PRESC_W:0] presc;
    logic [RMNT_PRESC_W:0] next_presc;
    logic [15:0]           left;
    logic [15:0]           next_left;
    logic                  next_busy;
    logic                  next_done;

    always_comb begin
        next_presc = presc;
        next_left  = left;
        next_busy  = busy_o;
        next_done  = 1'b0;
        if (start_i) begin
            next_presc = step_len_i - 1'b1;
            next_left  = steps_i;
            next_busy  = (steps_i != 16'h0000);
        end else if (stop_i) begin
            next_busy  = 1'b0;
        end else if (busy_o) begin
            if (presc != '0) begin
                next_presc = presc - 1'b1;
            end else begin
                next_presc = step_len_i - 1'b1;
                next_left  = left - 16'h0001;
                if (left == 16'h0001) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc  <= '0;
            left   <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            presc  <= next_presc;
            left   <= next_left;
            busy_o <= next_busy;
            done_o <= next_done;
        end
    end
endmodule : rmnt_step_counter
`default_nettype wire

// >>> verif/rmnt_timers_asserts.sv
// Checker for the timer block, seen only through its top ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module rmnt_timers_chk
    import rmnt_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    input  wire logic [5:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] RDATA_O,
    input  wire logic       TX_END_I,
    input  wire logic       RX_DATA_I,
    input  wire logic       RX_DATA_O,
    input  wire logic       RX_MASKED_O,
    input  wire logic       IRQ_O
);
    // ----------------------------------------------------------
    // Length of the current masked stretch
    // ----------------------------------------------------------
    // Wide enough for the longest bit rate detection mask
    logic [17:0] run_len;
    logic [17:0] next_run_len;
    always_comb begin
        next_run_len = RX_MASKED_O ? run_len + 18'h00001 : 18'h00000;
    end
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            run_len <= 18'h00000;
        end else begin
            run_len <= next_run_len;
        end
    end

    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    rx_block_a: assert property (RX_MASKED_O |-> !RX_DATA_O)
        else $error("receiver output passed while masked");
    rx_pass_a: assert property (!RX_MASKED_O && !$past(RX_MASKED_O)
        && !$past(TX_END_I) && !$past(RST_I)
        |-> RX_DATA_O == $past(RX_DATA_I))
        else $error("receiver output not passed when unmasked");
    mask_start_a: assert property (TX_END_I ##1
        (!(WR_I && ADDR_I == RMNT_ADDR_COMMAND)) [*7]
        |=> RX_MASKED_O && run_len > 18'h00006)
        else $error("mask not started by end of transmission");
    mask_min_a: assert property ($fell(RX_MASKED_O)
        && !($past(WR_I, 2) && $past(ADDR_I, 2) == RMNT_ADDR_COMMAND)
        |-> run_len > 18'h000FE)
        else $error("mask shorter than minimum");
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside read answer");
    unmapped_rd_a: assert property ($past(RD_I) &&
        $past(ADDR_I) == 6'h3F |-> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    irq_hold_a: assert property (IRQ_O && !WR_I |=> IRQ_O)
        else $error("interrupt dropped without a write");
    irq_gate_a: assert property (WR_I && ADDR_I == RMNT_ADDR_IRQ_MASK
        && WDATA_I == 8'h00 |=> !IRQ_O)
        else $error("interrupt high with all sources masked");

    cover property ($rose(IRQ_O));
    cover property ($fell(RX_MASKED_O));
    cover property ($past(RD_I) && RDATA_O != 8'h00);
endmodule : rmnt_timers_chk

bind rmnt_timers rmnt_timers_chk u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TX_END_I(TX_END_I), .RX_DATA_I(RX_DATA_I), .RX_DATA_O(RX_DATA_O),
    .RX_MASKED_O(RX_MASKED_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// >>> verif/rmnt_front_model.sv
// Front-end model: frame logic event pulses and a receiver bit stream.
// Assumes its tasks are called from the bench on the block's clock.
`timescale 1ns/1ns
`default_nettype none
module rmnt_front_model (
    input  wire logic clk_i,
    output logic      tx_end_o,
    output logic      tx_off_o,
    output logic      reply_o,
    output var logic  rx_data_o
);
    logic [2:0] ev;
    assign {reply_o, tx_off_o, tx_end_o} = ev;
    initial ev = 3'h0;

    // Receiver output never holds still, so a stuck gate shows
    initial rx_data_o = 1'b0;
    always @(posedge clk_i) begin
        rx_data_o <= ~rx_data_o;
    end

    // One-cycle event: 0 end of tx, 1 transmitter off, 2 reply
    task automatic pulse(input int sel);
        @(posedge clk_i);
        ev <= 3'h1 << sel;
        @(posedge clk_i);
        ev <= 3'h0;
    endtask : pulse
endmodule : rmnt_front_model
`default_nettype wire

// >>> verif/rmnt_timers_tb.sv
// Self-checking bench for the mask and no-response timer block.
// Assumes the checker binds itself; the front-end model makes events.
`timescale 1ns/1ns
`default_nettype none
module rmnt_timers_tb import rmnt_pkg::*;;
    logic       clk;
    logic       rst;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    wire  [7:0] rdata;
    wire        tx_end, tx_off, reply, rx_in, rx_out, rx_masked, irq;
    int         error_cnt = 0;
    int         tests_run = 0;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    rmnt_timers DUT (
        .REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TX_END_I(tx_end),
        .TX_OFF_I(tx_off), .REPLY_I(reply), .RX_DATA_I(rx_in),
        .RX_DATA_O(rx_out), .RX_MASKED_O(rx_masked), .IRQ_O(irq)
    );
    rmnt_front_model u_fe (
        .clk_i(clk), .tx_end_o(tx_end), .tx_off_o(tx_off),
        .reply_o(reply), .rx_data_o(rx_in)
    );

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        #1;
        chk(irq, 1'b0);
    endtask : quiet

    // Start by source 0 end of tx, 1 tx off, 2 command; cycles to irq
    task automatic run_timer(input int src, input int exp);
        int n;
        n = 0;
        if (src == 2) wr_reg(RMNT_ADDR_COMMAND, 8'h02);
        else u_fe.pulse(src);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < exp + 50);
        chk(n, exp);
        if (n >= exp + 50) results();
        wr_reg(RMNT_ADDR_IRQ_STATUS, 8'h03);
        chk(irq, 1'b0);
    endtask : run_timer

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_mask();
        logic [7:0] cnt [6] = '{8'h00, 8'h04, 8'h05, 8'hFF, 8'h08, 8'h08};
        logic [7:0] md [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
        int exp [6] = '{257, 257, 321, 16321, 4097, 513};
        wr_reg(RMNT_ADDR_IRQ_MASK, 8'h02);
        foreach (cnt[i]) begin
            wr_reg(RMNT_ADDR_MODE, md[i]);
            wr_reg(RMNT_ADDR_MASK_TIME, cnt[i]);
            run_timer(0, exp[i]);
        end
        wr_reg(RMNT_ADDR_MODE, 8'h00);
    endtask : t_mask

    task automatic t_nr();
        wr_reg(RMNT_ADDR_IRQ_MASK, 8'h01);
        u_fe.pulse(0);
        quiet(300);
        wr_reg(RMNT_ADDR_NR_LOW, 8'h03);
        run_timer(0, 193);
        wr_reg(RMNT_ADDR_TIMER_CTRL, 8'h01);
        wr_reg(RMNT_ADDR_NR_LOW, 8'h01);
        run_timer(0, 4097);
        wr_reg(RMNT_ADDR_TIMER_CTRL, 8'h00);
        wr_reg(RMNT_ADDR_NR_HIGH, 8'h01);
        wr_reg(RMNT_ADDR_NR_LOW, 8'h00);
        run_timer(0, 16385);
        wr_reg(RMNT_ADDR_NR_HIGH, 8'h00);
        wr_reg(RMNT_ADDR_NR_LOW, 8'h03);
        u_fe.pulse(0);
        repeat (100) @(posedge clk);
        run_timer(2, 193);
    endtask : t_nr

    task automatic t_irq_reply_nfc();
        u_fe.pulse(0);
        repeat (200) @(posedge clk);
        rd_reg(RMNT_ADDR_IRQ_STATUS, 8'h01);
        wr_reg(RMNT_ADDR_IRQ_MASK, 8'h00);
        chk(irq, 1'b0);
        wr_reg(RMNT_ADDR_IRQ_MASK, 8'h01);
        chk(irq, 1'b1);
        wr_reg(RMNT_ADDR_IRQ_STATUS, 8'h03);
        u_fe.pulse(0);
        repeat (50) @(posedge clk);
        u_fe.pulse(2);
        quiet(300);
        wr_reg(RMNT_ADDR_MODE, 8'h04);
        u_fe.pulse(0);
        quiet(300);
        run_timer(1, 193);
        wr_reg(RMNT_ADDR_MODE, 8'h00);
    endtask : t_irq_reply_nfc

    task automatic t_default();
        wr_reg(RMNT_ADDR_MASK_TIME, 8'h20);
        // Short step: an unstopped timer would fire inside the quiet span
        wr_reg(RMNT_ADDR_TIMER_CTRL, 8'h02);
        u_fe.pulse(0);
        wr_reg(RMNT_ADDR_COMMAND, 8'h01);
        quiet(300);
        rd_reg(RMNT_ADDR_MASK_TIME, 8'h08);
        rd_reg(RMNT_ADDR_NR_LOW, 8'h00);
        rd_reg(RMNT_ADDR_TIMER_CTRL, 8'h00);
        rd_reg(RMNT_ADDR_IRQ_MASK, 8'h01);
    endtask : t_default

    initial begin
        {rst, wr, rd, addr, wdata} <= {1'b1, 1'b0, 1'b0, 6'h00, 8'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(RMNT_ADDR_MASK_TIME, 8'h08);
        rd_reg(RMNT_ADDR_NR_HIGH, 8'h00);
        rd_reg(6'h3F, 8'h00);
        t_mask();
        t_nr();
        t_irq_reply_nfc();
        t_default();
        results();
    end
endmodule : rmnt_timers_tb
`default_nettype wire
